/* rtl/lcpwm_defs.svh */
// Offsets, field positions, reset values and timing counts of the long-cycle pwm
`ifndef LCPWM_DEFS_SVH
`define LCPWM_DEFS_SVH

// ****************************************
// Register byte addresses (word aligned)
// ****************************************
`define LCPWM_OFF_CMP_LO    8'h00
`define LCPWM_OFF_CMP_HI    8'h04
`define LCPWM_OFF_MODE      8'h08
`define LCPWM_OFF_CTRL      8'h0c
`define LCPWM_OFF_COUNT     8'h10
`define LCPWM_OFF_IRQ_STAT  8'h14
`define LCPWM_OFF_IRQ_MASK  8'h18

// ****************************************
// Mode control fields
// ****************************************
`define LCPWM_MODE_PWM_BIT  1
`define LCPWM_MODE_MAT_BIT  3
`define LCPWM_MODE_ECOM_BIT 6

// ****************************************
// Long pwm control fields
// ****************************************
`define LCPWM_CTRL_CYCLE_LENGTH_SELECT_LSB 0
`define LCPWM_CTRL_CYCLE_LENGTH_SELECT_MSB 1
`define LCPWM_CTRL_LONG_CYCLE_OVERFLOW_FLAG_BIT  5
`define LCPWM_CTRL_RELOAD_SELECT_BIT 7

// ****************************************
// Interrupt bits
// ****************************************
`define LCPWM_IRQ_LONG_CYCLE_OVERFLOW_FLAG_BIT  0
`define LCPWM_IRQ_CCF_BIT   1

// ****************************************
// Reset values
// ****************************************
`define LCPWM_RST_MODE      8'h00
`define LCPWM_RST_CTRL      8'h00
`define LCPWM_RST_CMP       16'h0000
`define LCPWM_RST_CNT       16'h0000

// ****************************************
// Cycle periods in counter clocks
// ****************************************
`define LCPWM_PERIOD_9      512
`define LCPWM_PERIOD_10     1024
`define LCPWM_PERIOD_11     2048

`endif

/* rtl/lcpwm_pkg.sv */
// Types shared by the long-cycle pwm modules
package lcpwm_pkg;

  // ****************************************
  // Cycle length selection
  // ****************************************
  typedef enum logic [1:0] {
    lcpwm_len_8  = 2'b00,
    lcpwm_len_9  = 2'b01,
    lcpwm_len_10 = 2'b10,
    lcpwm_len_11 = 2'b11
  } lcpwm_len_e;

  typedef logic [15:0] lcpwm_word_t;

endpackage : lcpwm_pkg

/* rtl/lcpwm_counter.sv */
// Free-running counter with overflow detection at the selected length
`timescale 1ns/10ps
`default_nettype none
`include "lcpwm_defs.svh"
module lcpwm_counter
  import lcpwm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Configuration
  input  wire lcpwm_len_e  len_sel,
  // Counter state
  output logic [15:0]      count,
  output logic             ovf_pulse
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        ovf_wire;

  assign count_next = count_reg + 16'h0001;
  // Overflow out of bit N: low N bits wrap to zero on the next count
  assign ovf_wire   = (len_sel == lcpwm_len_9)  ? (count_reg[8:0]  == 9'h1ff)  :
                      (len_sel == lcpwm_len_10) ? (count_reg[9:0]  == 10'h3ff) :
                      (len_sel == lcpwm_len_11) ? (count_reg[10:0] == 11'h7ff) :
                                                  (count_reg[7:0]  == 8'hff);

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_reg <= `LCPWM_RST_CNT;
      ovf_pulse <= 1'b0;
    end else if (ce) begin
      count_reg <= count_next;
      ovf_pulse <= ovf_wire;
    end
  end

  assign count = count_reg;

endmodule : lcpwm_counter
`default_nettype wire

/* rtl/lcpwm_compare.sv */
// Compare of the low N counter bits against the channel compare value
`timescale 1ns/10ps
`default_nettype none
module lcpwm_compare
  import lcpwm_pkg::*;
(
  // Inputs
  input  wire logic [15:0] count,
  input  wire logic [15:0] cmp,
  input  wire lcpwm_len_e  len_sel,
  // Result
  output logic             match
);

  logic [10:0] len_mask;
  logic [10:0] diff;

  assign len_mask = (len_sel == lcpwm_len_9)  ? 11'h1ff :
                    (len_sel == lcpwm_len_10) ? 11'h3ff :
                    (len_sel == lcpwm_len_11) ? 11'h7ff : 11'h0ff;
  assign diff     = (count[10:0] ^ cmp[10:0]) & len_mask;
  // Only the low N bits take part in the compare
  assign match    = (diff == 11'h000);

endmodule : lcpwm_compare
`default_nettype wire

/* rtl/lcpwm_top.sv */
// Long-cycle 9/10/11-bit pwm channel with a classic Wishbone register slave
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "lcpwm_defs.svh"
module lcpwm_top
  import lcpwm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Channel output and interrupt
  output logic             chan_output_pin,
  output logic             irq
);

  // ****************************************
  // State
  // ****************************************
  logic [15:0] chan_compare_value_reg;
  logic [15:0] chan_compare_value_next;
  logic [15:0] reload_reg;
  logic [15:0] reload_next;
  logic [7:0]  chan_mode_control_reg;
  logic [7:0]  chan_mode_control_next;
  logic [7:0]  long_pwm_control_reg;
  logic [7:0]  long_pwm_control_next;
  logic        ccf_reg;
  logic        ccf_next;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_stat_next;
  logic [1:0]  irq_mask_reg;
  logic [1:0]  irq_mask_next;
  logic        out_reg;
  logic        out_next;
  logic        ack_reg;
  logic        err_reg;
  logic [31:0] rdata_reg;

  // ****************************************
  // Counter and comparator
  // ****************************************
  logic [15:0] count;
  logic        ovf_pulse;
  logic        match;
  lcpwm_len_e  len_sel;

  assign len_sel = lcpwm_len_e'(long_pwm_control_reg[`LCPWM_CTRL_CYCLE_LENGTH_SELECT_MSB:
                                                     `LCPWM_CTRL_CYCLE_LENGTH_SELECT_LSB]);

  lcpwm_counter u_counter (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .len_sel   (len_sel),
    .count     (count),
    .ovf_pulse (ovf_pulse)
  );

  lcpwm_compare u_compare (
    .count   (count),
    .cmp     (chan_compare_value_reg),
    .len_sel (len_sel),
    .match   (match)
  );

  // ****************************************
  // Mode decode
  // ****************************************
  logic comparator_enable;
  logic pwm_enable;
  logic match_flag_enable;
  logic reload_select;
  logic long_mode;
  logic match_evt;
  logic ovf_evt;

  assign comparator_enable = chan_mode_control_reg[`LCPWM_MODE_ECOM_BIT];
  assign pwm_enable        = chan_mode_control_reg[`LCPWM_MODE_PWM_BIT];
  assign match_flag_enable = chan_mode_control_reg[`LCPWM_MODE_MAT_BIT];
  assign reload_select     = long_pwm_control_reg[`LCPWM_CTRL_RELOAD_SELECT_BIT];
  // Eight-bit length is not long-cycle mode; output stays low there
  assign long_mode = comparator_enable & pwm_enable & (len_sel != lcpwm_len_8);
  // The counter's overflow strobe refers to the count just wrapped
  assign ovf_evt   = ce & ovf_pulse & long_mode;
  assign match_evt = ce & match & long_mode;

  // ****************************************
  // Wishbone decode
  // ****************************************
  logic req;
  logic wr;
  logic rd;
  logic hit_lo;
  logic hit_hi;
  logic hit_mode;
  logic hit_ctrl;
  logic hit_cnt;
  logic hit_stat;
  logic hit_mask;
  logic mapped;
  logic wr_lo;
  logic wr_hi;
  logic wr_mode;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;
  logic [15:0] shared_rd;
  logic [31:0] rdata_next;
  logic        ack_next;
  logic        err_next;

  // Answer one cycle after the take; ack drops the cycle after
  assign ack_next = req & mapped;
  assign err_next = req & ~mapped;

  // Single-cycle answer; ack drops the cycle after it was given
  assign req      = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign rd       = req & ~wb_we_i;
  assign hit_lo   = (wb_adr_i == `LCPWM_OFF_CMP_LO);
  assign hit_hi   = (wb_adr_i == `LCPWM_OFF_CMP_HI);
  assign hit_mode = (wb_adr_i == `LCPWM_OFF_MODE);
  assign hit_ctrl = (wb_adr_i == `LCPWM_OFF_CTRL);
  assign hit_cnt  = (wb_adr_i == `LCPWM_OFF_COUNT);
  assign hit_stat = (wb_adr_i == `LCPWM_OFF_IRQ_STAT);
  assign hit_mask = (wb_adr_i == `LCPWM_OFF_IRQ_MASK);
  assign mapped   = hit_lo | hit_hi | hit_mode | hit_ctrl | hit_cnt | hit_stat | hit_mask;
  assign wr_lo    = wr & hit_lo;
  assign wr_hi    = wr & hit_hi;
  assign wr_mode  = wr & hit_mode;
  assign wr_ctrl  = wr & hit_ctrl;
  assign wr_mask  = wr & hit_mask;
  assign rd_stat  = rd & hit_stat & wb_sel_i[0];

  assign shared_rd = reload_select ? reload_reg : chan_compare_value_reg;

  assign rdata_next = hit_lo   ? {24'h000000, shared_rd[7:0]} :
                      hit_hi   ? {24'h000000, shared_rd[15:8]} :
                      hit_mode ? {24'h000000, chan_mode_control_reg[7:1], ccf_reg} :
                      hit_ctrl ? {24'h000000, long_pwm_control_reg} :
                      hit_cnt  ? {16'h0000, count} :
                      hit_stat ? {30'h0, irq_stat_reg} :
                      hit_mask ? {30'h0, irq_mask_reg} : 32'h00000000;

  // ****************************************
  // Next-state logic
  // ****************************************
  logic sel_reload_wr;
  logic sel_cmp_wr;

  // Shared byte locations: one decode steers writes to either copy
  assign sel_reload_wr = reload_select;
  assign sel_cmp_wr    = ~reload_select;

  always_comb begin
    reload_next = reload_reg;
    if (wr_lo && sel_reload_wr) begin
      reload_next[7:0] = wb_dat_i[7:0];
    end
    if (wr_hi && sel_reload_wr) begin
      reload_next[15:8] = wb_dat_i[7:0];
    end
  end

  always_comb begin
    chan_compare_value_next = chan_compare_value_reg;
    if (ovf_evt) begin
      chan_compare_value_next = reload_reg;
    end
    // A bus write lands after the reload copy, so software's value wins
    if (wr_lo && sel_cmp_wr) begin
      chan_compare_value_next[7:0] = wb_dat_i[7:0];
    end
    if (wr_hi && sel_cmp_wr) begin
      chan_compare_value_next[15:8] = wb_dat_i[7:0];
    end
  end

  always_comb begin
    chan_mode_control_next = chan_mode_control_reg;
    if (wr_mode) begin
      chan_mode_control_next = wb_dat_i[7:0];
    end
    // Byte writes to the compare location steer the comparator enable
    if (wr_lo) begin
      chan_mode_control_next[`LCPWM_MODE_ECOM_BIT] = 1'b0;
    end
    if (wr_hi) begin
      chan_mode_control_next[`LCPWM_MODE_ECOM_BIT] = 1'b1;
    end
  end

  // ****************************************
  // Flags
  // ****************************************

  always_comb begin
    long_pwm_control_next = long_pwm_control_reg;
    if (wr_ctrl) begin
      long_pwm_control_next = wb_dat_i[7:0];
    end
    // Set beats a same-cycle clear
    if (ovf_evt) begin
      long_pwm_control_next[`LCPWM_CTRL_LONG_CYCLE_OVERFLOW_FLAG_BIT] = 1'b1;
    end
  end

  always_comb begin
    ccf_next = ccf_reg;
    if (wr_mode) begin
      ccf_next = wb_dat_i[0];
    end
    if (match_evt && match_flag_enable) begin
      ccf_next = 1'b1;
    end
  end

  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (rd_stat) begin
      irq_stat_next = 2'b00;
    end
    if (ovf_evt) begin
      irq_stat_next[`LCPWM_IRQ_LONG_CYCLE_OVERFLOW_FLAG_BIT] = 1'b1;
    end
    if (match_evt && match_flag_enable) begin
      irq_stat_next[`LCPWM_IRQ_CCF_BIT] = 1'b1;
    end
  end

  always_comb begin
    irq_mask_next = irq_mask_reg;
    if (wr_mask) begin
      irq_mask_next = wb_dat_i[1:0];
    end
  end

  // ****************************************
  // Output pin
  // ****************************************

  // Overflow clears before match so a match at count zero keeps high
  always_comb begin
    out_next = out_reg;
    if (!long_mode) begin
      out_next = 1'b0;
    end else if (match_evt) begin
      out_next = 1'b1;
    end else if (ovf_evt) begin
      out_next = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      chan_compare_value_reg <= `LCPWM_RST_CMP;
      reload_reg             <= `LCPWM_RST_CMP;
      chan_mode_control_reg  <= `LCPWM_RST_MODE;
      long_pwm_control_reg   <= `LCPWM_RST_CTRL;
      ccf_reg                <= 1'b0;
      irq_stat_reg           <= 2'b00;
      irq_mask_reg           <= 2'b00;
      out_reg                <= 1'b0;
    end else if (ce) begin
      chan_compare_value_reg <= chan_compare_value_next;
      reload_reg             <= reload_next;
      chan_mode_control_reg  <= {chan_mode_control_next[7:1], 1'b0};
      long_pwm_control_reg   <= long_pwm_control_next;
      ccf_reg                <= ccf_next;
      irq_stat_reg           <= irq_stat_next;
      irq_mask_reg           <= irq_mask_next;
      out_reg                <= out_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else if (ce) begin
      ack_reg   <= ack_next;
      err_reg   <= err_next;
      rdata_reg <= rd ? rdata_next : 32'h00000000;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  // Level output from a flop; built from next values so it has no lag
  logic irq_reg;
  logic irq_next;

  assign irq_next = |(irq_stat_next & irq_mask_next);

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= irq_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Read data fully registered, compare flag included
  assign wb_dat_o        = rdata_reg;
  assign wb_ack_o        = ack_reg;
  assign wb_err_o        = err_reg;
  assign chan_output_pin = out_reg;
  assign irq             = irq_reg;

endmodule : lcpwm_top
`default_nettype wire

/* bench/lcpwm_asserts.sv */
// Concurrent checks on the ports of the long-cycle pwm channel
`timescale 1ns/10ps
`default_nettype none
module lcpwm_checker (
  // Clock and control
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // Channel
  input wire logic        chan_output_pin,
  input wire logic        irq
);
  // ********
  // Request decode
  // ********
  wire req;
  wire mapped;
  assign req    = wb_cyc_i && wb_stb_i && ce && !wb_ack_o && !wb_err_o;
  assign mapped = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i <= 8'h18);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ********
  // Bus and channel properties
  // ********
  property p_take_ack;
    req && mapped |=> wb_ack_o && !wb_err_o;
  endproperty
  a_take_ack: assert property (p_take_ack) else $error("mapped request not acked");
  property p_take_err;
    req && (wb_adr_i > 8'h18) |=> wb_err_o && !wb_ack_o;
  endproperty
  a_take_err: assert property (p_take_err) else $error("unmapped request not refused");
  property p_ack_pulse;
    wb_ack_o && ce |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_err_pulse;
    wb_err_o && ce |=> !wb_err_o;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("err longer than one cycle");
  property p_one_answer;
    !(wb_ack_o && wb_err_o);
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("ack and err together");
  property p_no_spurious;
    !(wb_cyc_i && wb_stb_i) && ce |=> !wb_ack_o && !wb_err_o;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
  // Frozen clock enable must hold the pin, irq and ack outputs
  property p_freeze;
    !ce |=> $stable(chan_output_pin) && $stable(irq) && $stable(wb_ack_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("output moved while frozen");
  property p_reset_quiet;
    disable iff (1'b0) rst && ce |=> !wb_ack_o && !wb_err_o && !chan_output_pin && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output high after reset");
endmodule : lcpwm_checker
bind lcpwm_top lcpwm_checker u_chk (
  .mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .chan_output_pin(chan_output_pin), .irq(irq)
);
`default_nettype wire

/* bench/tb_pca_long_cycle_pwm.sv */
// Self-checking bench for the long-cycle pwm channel
`timescale 1ns/10ps
`default_nettype none
`include "lcpwm_defs.svh"
module tb_pca_long_cycle_pwm;
  import lcpwm_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic ex;} lcpwm_row_s;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic        pin;
  logic        irq;
  logic [7:0]  q;
  logic [7:0]  q1;
  logic        e;
  int          n_fail = 0;
  int          total_checks = 0;
  lcpwm_len_e  lens [3] = '{lcpwm_len_11, lcpwm_len_10, lcpwm_len_9};
  logic [15:0] cmps [3] = '{16'h07ff, 16'h00c0, 16'h0100};
  lcpwm_row_s  rows [16] = '{
    '{0, `LCPWM_OFF_CTRL, 8'h00, 8'h00, 0}, '{0, `LCPWM_OFF_MODE, 8'h00, 8'h00, 0},
    '{0, `LCPWM_OFF_IRQ_STAT, 8'h00, 8'h00, 0}, '{1, `LCPWM_OFF_MODE, 8'h08, 8'h00, 0},
    '{0, `LCPWM_OFF_MODE, 8'h00, 8'h08, 0}, '{1, `LCPWM_OFF_IRQ_MASK, 8'h03, 8'h00, 0},
    '{0, `LCPWM_OFF_IRQ_MASK, 8'h00, 8'h03, 0}, '{1, `LCPWM_OFF_CTRL, 8'h80, 8'h00, 0},
    '{1, `LCPWM_OFF_CMP_LO, 8'h5a, 8'h00, 0}, '{1, `LCPWM_OFF_CMP_HI, 8'h03, 8'h00, 0},
    '{0, `LCPWM_OFF_CMP_LO, 8'h00, 8'h5a, 0}, '{0, `LCPWM_OFF_CMP_HI, 8'h00, 8'h03, 0},
    '{1, `LCPWM_OFF_CTRL, 8'h00, 8'h00, 0}, '{0, `LCPWM_OFF_CMP_LO, 8'h00, 8'h00, 0},
    '{0, 8'h20, 8'h00, 8'h00, 1}, '{1, 8'hfc, 8'h00, 8'h00, 1}};
  lcpwm_top u_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .chan_output_pin(pin), .irq(irq));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ********
  // Shared tasks
  // ********
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Classic cycle: hold everything until ack or err is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    if (n >= 50) chk("bus answer", 12'h1, 12'h0);
    q = rdat[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk(nm, {4'h0, x}, {4'h0, q});
  endtask : rd
  task automatic run(input logic v, output int n);
    n = 0;
    while (pin === v && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 5000) chk("pin level run", 12'h0, 12'hfff);
  endtask : run
  // Same value into compare and reload, so every overflow keeps it
  task automatic setup(input logic [1:0] len, input logic [15:0] c);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `LCPWM_OFF_CTRL, {i[0], 5'h00, len});
      bus(1'b1, `LCPWM_OFF_CMP_LO, c[7:0]);
      bus(1'b1, `LCPWM_OFF_CMP_HI, c[15:8]);
    end
    bus(1'b1, `LCPWM_OFF_MODE, 8'h4a);
  endtask : setup
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    int hi;
    int lo;
    int x;
    int per;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("table read", {4'h0, rows[i].x}, {4'h0, q});
      chk("table err", {11'h0, rows[i].ex}, {11'h0, e});
    end
    for (int k = 0; k < 3; k++) begin
      per = 1 << (int'(lens[k]) + 8);
      setup(lens[k], cmps[k]);
      run(1'b1, x);
      run(1'b0, x);
      run(1'b1, x);
      run(1'b0, lo);
      run(1'b1, hi);
      chk("low time", 12'(cmps[k]), 12'(lo));
      chk("period", 12'(per), 12'(hi + lo));
    end
    // Fall just seen: both events are latched, the next one is far off
    chk("irq raised", 12'h1, {11'h0, irq});
    rd("status", `LCPWM_OFF_IRQ_STAT, 8'h03);
    rd("status cleared", `LCPWM_OFF_IRQ_STAT, 8'h00);
    rd("mode flag", `LCPWM_OFF_MODE, 8'h4b);
    rd("ctrl flag", `LCPWM_OFF_CTRL, 8'ha1);
    chk("irq dropped", 12'h0, {11'h0, irq});
    rd("reload readback", `LCPWM_OFF_CMP_LO, 8'h00);
    bus(1'b1, `LCPWM_OFF_IRQ_MASK, 8'h00);
    run(1'b0, x);
    repeat (3) @(posedge mclk);
    chk("irq masked", 12'h0, {11'h0, irq});
    rd("masked status", `LCPWM_OFF_IRQ_STAT, 8'h02);
    // New reload only; the next overflow must carry it into compare
    bus(1'b1, `LCPWM_OFF_CMP_LO, 8'h40);
    bus(1'b1, `LCPWM_OFF_CMP_HI, 8'h01);
    repeat (520) @(posedge mclk);
    bus(1'b1, `LCPWM_OFF_CTRL, 8'h01);
    rd("compare copy", `LCPWM_OFF_CMP_LO, 8'h40);
    bus(1'b1, `LCPWM_OFF_CMP_LO, 8'h00);
    bus(1'b0, `LCPWM_OFF_MODE, 8'h00);
    chk("enable cleared", 12'h0, {4'h0, q & 8'h40});
    repeat (3) @(posedge mclk);
    x = 0;
    repeat (2100) begin
      @(posedge mclk);
      if (pin !== 1'b0) x++;
    end
    chk("zero duty", 12'h0, 12'(x));
    bus(1'b1, `LCPWM_OFF_CMP_HI, 8'h00);
    bus(1'b0, `LCPWM_OFF_MODE, 8'h00);
    chk("enable set", 12'h40, {4'h0, q & 8'h40});
    bus(1'b1, `LCPWM_OFF_CTRL, 8'h00);
    repeat (300) @(posedge mclk);
    x = 0;
    repeat (600) begin
      @(posedge mclk);
      if (pin !== 1'b0) x++;
    end
    chk("eight bit mode", 12'h0, 12'(x));
    // Counter steps once a clock; a frozen enable adds nothing
    for (int f = 0; f < 2; f++) begin
      bus(1'b0, `LCPWM_OFF_COUNT, 8'h00);
      q1 = q;
      if (f == 1) begin
        ce <= 1'b0;
        repeat (10) @(posedge mclk);
        ce <= 1'b1;
      end
      bus(1'b0, `LCPWM_OFF_COUNT, 8'h00);
      chk("count step", 12'h3, {4'h0, q - q1});
    end
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    chk("pin after reset", 12'h0, {11'h0, pin});
    rd("mode after reset", `LCPWM_OFF_MODE, 8'h00);
    rd("ctrl after reset", `LCPWM_OFF_CTRL, 8'h00);
    report_and_stop();
  end
endmodule : tb_pca_long_cycle_pwm
`default_nettype wire
